// ### rtl/bcd_map.svh
`ifndef BCD_MAP_SVH
`define BCD_MAP_SVH

// register offsets in the port 0 configuration space
`define BCD_OFS_PORT3 12'he26
`define BCD_OFS_PORT4 12'he28

// field positions inside each 16-bit register
`define BCD_BIT_ERR_FWD 1
`define BCD_BIT_ALIAS_BLK 2
`define BCD_BIT_DISP_DEC 3
`define BCD_BIT_DISP_FULL 4
`define BCD_FIELD_LSB 1
`define BCD_FIELD_MSB 4
`define BCD_CTRL_RESET 4'h0

// legacy display memory range
`define BCD_DISP_MEM_LO 32'h000a_0000
`define BCD_DISP_MEM_HI 32'h000b_ffff

// legacy display i/o ranges, low ten address bits
`define BCD_DISP_IO_A_LO 10'h3b0
`define BCD_DISP_IO_A_HI 10'h3bb
`define BCD_DISP_IO_B_LO 10'h3c0
`define BCD_DISP_IO_B_HI 10'h3df

// upper 768 bytes of each 1-KB block start at offset 100h
`define BCD_ALIAS_MIN 10'h100
`define BCD_IO_HI_ZERO 16'h0000
`define BCD_IO_MID_ZERO 6'h00

`endif

// ### rtl/bcd_pkg.sv
package bcd_pkg;

    // stored control fields, bit 3 of this struct is register bit 4
    typedef struct packed {
        logic disp_full;
        logic disp_dec;
        logic alias_blk;
        logic err_fwd;
    } bcd_ctrl_t;

    // direction of a request crossing the port
    typedef enum logic {
        BCD_DIR_DOWN,
        BCD_DIR_UP
    } bcd_dir_t;

endpackage : bcd_pkg

// ### rtl/bcd_port_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcd_map.svh"

module bcd_port_decode
    import bcd_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    bcd_port_if.dec port
);
    logic low64k;
    logic alias_top;
    logic disp_mem;
    logic disp_io_lo;
    logic disp_io;
    logic alias_cut;
    logic pass_next;

    // address classification, all combinational on the request
    always_comb begin
        low64k = (port.req_addr[31:16] == `BCD_IO_HI_ZERO);
        alias_top = (port.req_addr[9:0] >= `BCD_ALIAS_MIN);
        disp_mem = port.ctrl.disp_dec && (port.req_addr >= `BCD_DISP_MEM_LO) &&
            (port.req_addr <= `BCD_DISP_MEM_HI);
        disp_io_lo = ((port.req_addr[9:0] >= `BCD_DISP_IO_A_LO) &&
            (port.req_addr[9:0] <= `BCD_DISP_IO_A_HI)) ||
            ((port.req_addr[9:0] >= `BCD_DISP_IO_B_LO) &&
            (port.req_addr[9:0] <= `BCD_DISP_IO_B_HI));
        // full decode only counts while display decode is on
        disp_io = port.ctrl.disp_dec && low64k && disp_io_lo &&
            (!port.ctrl.disp_full ||
            (port.req_addr[15:10] == `BCD_IO_MID_ZERO));
        // alias filter only inside the window and the low 64 KB
        alias_cut = port.ctrl.alias_blk && port.io_win && low64k && alias_top;
    end

    // forwarding decision; display hits bypass windows and alias filter
    always_comb begin
        pass_next = 1'b0;
        case (port.req_dir)
            BCD_DIR_DOWN: begin
                if (port.req_io) begin
                    pass_next = port.io_en &&
                        (disp_io || (port.io_win && !alias_cut));
                end else begin
                    pass_next = port.mem_en && (disp_mem || port.mem_win);
                end
            end
            BCD_DIR_UP: begin
                if (port.req_io) begin
                    pass_next = !disp_io && (!port.io_win || alias_cut);
                end else begin
                    pass_next = !disp_mem && !port.mem_win;
                end
            end
            default: pass_next = 1'b0;
        endcase
    end

    // decision registered so the top sees flop outputs
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            port.fwd_valid <= 1'b0;
            port.fwd_pass <= 1'b0;
        end else begin
            port.fwd_valid <= port.req_valid;
            port.fwd_pass <= port.req_valid && pass_next;
        end
    end

    // error messages from the secondary side
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            port.err_fwd <= 1'b0;
            port.serr_set <= 1'b0;
        end else begin
            port.err_fwd <= port.err_msg && port.ctrl.err_fwd;
            port.serr_set <= port.err_msg && port.ctrl.err_fwd && port.serr_en;
        end
    end
endmodule : bcd_port_decode

`default_nettype wire

// ### rtl/bcd_port_if.sv
`timescale 1ns/1ps
`default_nettype none

interface bcd_port_if;
    import bcd_pkg::*;
    bcd_ctrl_t ctrl;
    logic io_en;
    logic mem_en;
    logic serr_en;
    logic req_valid;
    bcd_dir_t req_dir;
    logic req_io;
    logic [31:0] req_addr;
    logic io_win;
    logic mem_win;
    logic err_msg;
    logic fwd_valid;
    logic fwd_pass;
    logic err_fwd;
    logic serr_set;

    modport cfg (
        output ctrl, io_en, mem_en, serr_en, req_valid, req_dir, req_io,
        output req_addr, io_win, mem_win, err_msg,
        input fwd_valid, fwd_pass, err_fwd, serr_set
    );
    modport dec (
        input ctrl, io_en, mem_en, serr_en, req_valid, req_dir, req_io,
        input req_addr, io_win, mem_win, err_msg,
        output fwd_valid, fwd_pass, err_fwd, serr_set
    );
endinterface : bcd_port_if

`default_nettype wire

// ### rtl/bcd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcd_map.svh"

module bcd_top
    import bcd_pkg::*;
#(
    parameter int NPORT = 2
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [11:0] i_cfg_addr,
    input wire logic [1:0] i_cfg_be,
    input wire logic [15:0] i_cfg_wdata,
    output logic [15:0] o_cfg_rdata,
    output logic o_cfg_ack,
    input wire logic [NPORT-1:0] i_cmd_io_en,
    input wire logic [NPORT-1:0] i_cmd_mem_en,
    input wire logic [NPORT-1:0] i_cmd_serr_en,
    input wire logic [NPORT-1:0] i_req_valid,
    input wire logic [NPORT-1:0] i_req_up,
    input wire logic [NPORT-1:0] i_req_io,
    input wire logic [NPORT-1:0][31:0] i_req_addr,
    input wire logic [NPORT-1:0] i_io_win_hit,
    input wire logic [NPORT-1:0] i_mem_win_hit,
    input wire logic [NPORT-1:0] i_err_msg,
    output logic [NPORT-1:0] o_fwd_valid,
    output logic [NPORT-1:0] o_fwd_pass,
    output logic [NPORT-1:0] o_err_fwd,
    output logic [NPORT-1:0] o_serr_set
);
    localparam logic [11:0] OFS [2] = '{`BCD_OFS_PORT3, `BCD_OFS_PORT4};

    bcd_ctrl_t ctrl_reg [NPORT];
    logic [15:0] rdata_next;

    // one independent copy per port, each with its own enables
    for (genvar p = 0; p < NPORT; p++) begin : g_port
        bcd_port_if pif ();

        assign pif.ctrl = ctrl_reg[p];
        assign pif.io_en = i_cmd_io_en[p];
        assign pif.mem_en = i_cmd_mem_en[p];
        assign pif.serr_en = i_cmd_serr_en[p];
        assign pif.req_valid = i_req_valid[p];
        assign pif.req_dir = i_req_up[p] ? BCD_DIR_UP : BCD_DIR_DOWN;
        assign pif.req_io = i_req_io[p];
        assign pif.req_addr = i_req_addr[p];
        assign pif.io_win = i_io_win_hit[p];
        assign pif.mem_win = i_mem_win_hit[p];
        assign pif.err_msg = i_err_msg[p];
        assign o_fwd_valid[p] = pif.fwd_valid;
        assign o_fwd_pass[p] = pif.fwd_pass;
        assign o_err_fwd[p] = pif.err_fwd;
        assign o_serr_set[p] = pif.serr_set;

        bcd_port_decode u_dec (
            .i_sys_clk(i_sys_clk),
            .i_reset_n(i_reset_n),
            .port(pif.dec)
        );

        // all fields live in byte 0; reserved bits are never stored
        always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
                ctrl_reg[p] <= `BCD_CTRL_RESET;
            end else if (i_cfg_wr && i_cfg_be[0] && (i_cfg_addr == OFS[p])) begin
                ctrl_reg[p] <= i_cfg_wdata[`BCD_FIELD_MSB:`BCD_FIELD_LSB];
            end
        end
    end

    // read mux; unmapped offsets read zero so a probe is harmless
    always_comb begin
        rdata_next = 16'h0000;
        for (int p = 0; p < NPORT; p++) begin
            if (i_cfg_addr == OFS[p]) begin
                rdata_next = {11'h000, ctrl_reg[p], 1'b0};
            end
        end
    end

    // read data and acknowledge one cycle after the strobe
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cfg_rdata <= 16'h0000;
            o_cfg_ack <= 1'b0;
        end else begin
            o_cfg_rdata <= i_cfg_rd ? rdata_next : 16'h0000;
            o_cfg_ack <= i_cfg_rd || i_cfg_wr;
        end
    end

    // checks on port 3 (index 0); port 4 uses the same decode module
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);

    logic p3_low64k;
    logic p3_alias;
    assign p3_low64k = (i_req_addr[0][31:16] == `BCD_IO_HI_ZERO);
    assign p3_alias = (i_req_addr[0][9:0] >= `BCD_ALIAS_MIN);

    sequence s_p3_down_io;
        i_req_valid[0] && !i_req_up[0] && i_req_io[0];
    endsequence

    a_err_gate_off: assert property (
        (i_err_msg[0] && !ctrl_reg[0].err_fwd) |=> !o_err_fwd[0] && !o_serr_set[0])
        else $error("error message passed with forwarding off");
    a_serr_both_en: assert property (
        o_serr_set[0] |-> $past(ctrl_reg[0].err_fwd && i_cmd_serr_en[0] && i_err_msg[0]))
        else $error("system error set without both enables");
    a_alias_outside: assert property (
        (s_p3_down_io and ##0 (ctrl_reg[0].alias_blk && !ctrl_reg[0].disp_dec &&
        !p3_low64k && i_io_win_hit[0] && i_cmd_io_en[0])) |=> o_fwd_pass[0])
        else $error("alias filter applied above 64 KB");
    a_alias_block: assert property (
        (s_p3_down_io and ##0 (ctrl_reg[0].alias_blk && !ctrl_reg[0].disp_dec &&
        p3_low64k && p3_alias && i_io_win_hit[0])) |=> o_fwd_valid[0] && !o_fwd_pass[0])
        else $error("alias address forwarded downstream");
    a_alias_up: assert property (
        (i_req_valid[0] && i_req_up[0] && i_req_io[0] && ctrl_reg[0].alias_blk &&
        !ctrl_reg[0].disp_dec && p3_low64k && p3_alias && i_io_win_hit[0])
        |=> o_fwd_pass[0])
        else $error("alias address not forwarded upstream");
    a_window_plain: assert property (
        (s_p3_down_io and ##0 (!ctrl_reg[0].alias_blk && i_io_win_hit[0] &&
        i_cmd_io_en[0])) |=> o_fwd_pass[0])
        else $error("window i/o dropped with alias block clear");
    a_disp_mem_fwd: assert property (
        (i_req_valid[0] && !i_req_up[0] && !i_req_io[0] && ctrl_reg[0].disp_dec &&
        i_cmd_mem_en[0] && (i_req_addr[0] >= `BCD_DISP_MEM_LO) &&
        (i_req_addr[0] <= `BCD_DISP_MEM_HI)) |=> o_fwd_pass[0])
        else $error("display memory not forwarded");
    a_disp_io_alias: assert property (
        (s_p3_down_io and ##0 (ctrl_reg[0].disp_dec && !ctrl_reg[0].disp_full &&
        p3_low64k && i_req_addr[0][9:0] == `BCD_DISP_IO_B_LO && i_cmd_io_en[0]))
        |=> o_fwd_pass[0])
        else $error("display i/o alias not forwarded");
    a_disp_up_block: assert property (
        (i_req_valid[0] && i_req_up[0] && !i_req_io[0] && ctrl_reg[0].disp_dec &&
        (i_req_addr[0] >= `BCD_DISP_MEM_LO) && (i_req_addr[0] <= `BCD_DISP_MEM_HI))
        |=> o_fwd_valid[0] && !o_fwd_pass[0])
        else $error("display memory forwarded upstream");
    a_disp_need_en: assert property (
        (s_p3_down_io and ##0 !i_cmd_io_en[0]) |=> !o_fwd_pass[0])
        else $error("i/o forwarded without access enable");
    a_full_decode: assert property (
        (s_p3_down_io and ##0 (ctrl_reg[0].disp_dec && ctrl_reg[0].disp_full &&
        !i_io_win_hit[0] && i_req_addr[0][15:10] != `BCD_IO_MID_ZERO))
        |=> !o_fwd_pass[0])
        else $error("16-bit decode matched an alias");
    a_field_write: assert property (
        (i_cfg_wr && i_cfg_be[0] && i_cfg_addr == `BCD_OFS_PORT3)
        |=> ctrl_reg[0] == $past(i_cfg_wdata[`BCD_FIELD_MSB:`BCD_FIELD_LSB]))
        else $error("control field write lost");
    a_rsvd_zero: assert property (
        o_cfg_ack |-> o_cfg_rdata[0] == 1'b0 && o_cfg_rdata[15:5] == 11'h000)
        else $error("reserved bits read nonzero");
    a_port_indep: assert property (
        (i_cfg_wr && i_cfg_addr == `BCD_OFS_PORT3) |=> $stable(ctrl_reg[1]))
        else $error("port 3 write disturbed port 4");

    c_alias_block: cover property (s_p3_down_io ##1 (o_fwd_valid[0] && !o_fwd_pass[0]));
    c_disp_fwd: cover property (ctrl_reg[0].disp_dec ##1 o_fwd_pass[0]);
    c_serr: cover property (o_serr_set[0]);
    c_readback: cover property (i_cfg_rd && i_cfg_addr == `BCD_OFS_PORT4 ##1 o_cfg_ack);
endmodule : bcd_top

`default_nettype wire

// ### tb/tb_bridge_control_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcd_map.svh"
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("unexpected %s expected %h seen %h", nm, exp, got); end end

module tb_bridge_control_decode;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cfg_wr = 1'b0;
    logic cfg_rd = 1'b0;
    logic [11:0] cfg_addr = 12'h000;
    logic [1:0] cfg_be = 2'h0;
    logic [15:0] cfg_wdata = 16'h0000;
    logic [15:0] cfg_rdata;
    logic cfg_ack;
    logic [1:0] io_en = 2'h0;
    logic [1:0] mem_en = 2'h0;
    logic [1:0] serr_en = 2'h0;
    logic [1:0] req_valid = 2'h0;
    logic [1:0] req_up = 2'h0;
    logic [1:0] req_io = 2'h0;
    logic [1:0][31:0] req_addr = '0;
    logic [1:0] io_win = 2'h0;
    logic [1:0] mem_win = 2'h0;
    logic [1:0] err_msg = 2'h0;
    logic [1:0] fwd_valid;
    logic [1:0] fwd_pass;
    logic [1:0] err_fwd;
    logic [1:0] serr_set;
    // model copy of the stored fields, register bit positions
    logic [15:0] mctrl [2] = '{16'h0000, 16'h0000};
    logic [3:0] exp_out [2];
    int miscompares = 0;
    int total_checks = 0;
    // corner addresses around the display ranges and the alias boundary
    logic [31:0] edges [16] = '{32'h3af, 32'h3b0, 32'h3bb, 32'h3bc, 32'h3bf, 32'h3c0,
        32'h3df, 32'h3e0, 32'hff, 32'h100, 32'h9ffff, 32'ha0000, 32'hbffff, 32'hc0000,
        32'h1_03c0, 32'h43c0};

    bcd_top #(.NPORT(2)) dut (.i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_cfg_wr(cfg_wr),
        .i_cfg_rd(cfg_rd), .i_cfg_addr(cfg_addr), .i_cfg_be(cfg_be), .i_cfg_wdata(cfg_wdata),
        .o_cfg_rdata(cfg_rdata), .o_cfg_ack(cfg_ack), .i_cmd_io_en(io_en),
        .i_cmd_mem_en(mem_en), .i_cmd_serr_en(serr_en), .i_req_valid(req_valid),
        .i_req_up(req_up), .i_req_io(req_io), .i_req_addr(req_addr), .i_io_win_hit(io_win),
        .i_mem_win_hit(mem_win), .i_err_msg(err_msg), .o_fwd_valid(fwd_valid),
        .o_fwd_pass(fwd_pass), .o_err_fwd(err_fwd), .o_serr_set(serr_set));

    // 10 MHz
    always #50 sys_clk = ~sys_clk;

    // inputs always move 1 ns after the edge so sampling never races
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask : tick

    function automatic int port_of(input logic [11:0] addr);
        return (addr == `BCD_OFS_PORT3) ? 0 : (addr == `BCD_OFS_PORT4) ? 1 : -1;
    endfunction : port_of

    task automatic cfg_write(input logic [11:0] addr, input logic [1:0] be, input logic [15:0] d);
        int p;
        p = port_of(addr);
        cfg_wr = 1'b1;
        cfg_addr = addr;
        cfg_be = be;
        cfg_wdata = d;
        tick();
        cfg_wr = 1'b0;
        `CHK("write ack", 1'b1, cfg_ack)
        if (p >= 0 && be[0]) begin
            mctrl[p] = d & 16'h001e;
        end
    endtask : cfg_write

    task automatic cfg_read(input logic [11:0] addr);
        int p;
        p = port_of(addr);
        cfg_rd = 1'b1;
        cfg_addr = addr;
        tick();
        cfg_rd = 1'b0;
        `CHK("read ack", 1'b1, cfg_ack)
        `CHK("read data", (p >= 0) ? mctrl[p] : 16'h0000, cfg_rdata)
    endtask : cfg_read

    // reference decision, written straight from the forwarding rules
    function automatic logic [3:0] model(input int p);
        logic [15:0] c;
        logic [31:0] a;
        logic lo64, cut, inr, dio, dmem, pass;
        c = mctrl[p];
        a = req_addr[p];
        lo64 = (a[31:16] == 16'h0000);
        cut = c[2] & io_win[p] & lo64 & (a[9:0] >= 10'h100);
        inr = (a[9:0] >= 10'h3b0 && a[9:0] <= 10'h3bb) || (a[9:0] >= 10'h3c0 && a[9:0] <= 10'h3df);
        dio = c[3] & lo64 & inr & (!c[4] | (a[15:10] == 6'h00));
        dmem = c[3] & (a >= 32'h000a_0000) & (a <= 32'h000b_ffff);
        if (!req_up[p]) begin
            pass = req_io[p] ? io_en[p] & (dio | io_win[p] & !cut) : mem_en[p] & (dmem | mem_win[p]);
        end else begin
            pass = req_io[p] ? !dio & (!io_win[p] | cut) : !dmem & !mem_win[p];
        end
        return {req_valid[p], req_valid[p] & pass, err_msg[p] & c[1], err_msg[p] & c[1] & serr_en[p]};
    endfunction : model

    task automatic drive_port(input int p);
        case ($urandom_range(3))
            0: req_addr[p] = $urandom;
            1: req_addr[p] = {16'h0000, 16'($urandom)};
            2: req_addr[p] = edges[$urandom_range(15)];
            default: req_addr[p] = 32'h0009_0000 + $urandom_range(32'h0004_0000);
        endcase
        {req_valid[p], req_up[p], req_io[p], io_win[p]} = 4'($urandom);
        {mem_win[p], io_en[p], mem_en[p], serr_en[p], err_msg[p]} = 5'($urandom);
        exp_out[p] = model(p);
    endtask : drive_port

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    // hang guard, roughly six times the expected run
    initial begin
        #1_000_000;
        miscompares++;
        end_sim();
    end

    initial begin
        void'($urandom(32));
        repeat (16) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        tick();
        for (int ep = 0; ep < 24; ep++) begin
            cfg_read(`BCD_OFS_PORT3);
            cfg_read(`BCD_OFS_PORT4);
            cfg_write(`BCD_OFS_PORT3, 2'b01, 16'($urandom));
            cfg_write(`BCD_OFS_PORT4, 2'b11, 16'($urandom));
            cfg_write(`BCD_OFS_PORT4, 2'b10, 16'hffff);
            cfg_write(12'he2a, 2'b01, 16'hffff);
            cfg_read(`BCD_OFS_PORT3);
            cfg_read(`BCD_OFS_PORT4);
            cfg_read(12'he2a);
            // back-to-back requests on both ports, checked the cycle after
            for (int i = 0; i < 64; i++) begin
                drive_port(0);
                drive_port(1);
                tick();
                for (int p = 0; p < 2; p++) begin
                    `CHK("fwd valid", exp_out[p][3], fwd_valid[p])
                    `CHK("fwd pass", exp_out[p][2], fwd_pass[p])
                    `CHK("err fwd", exp_out[p][1], err_fwd[p])
                    `CHK("serr set", exp_out[p][0], serr_set[p])
                end
            end
            req_valid = 2'h0;
            err_msg = 2'h0;
            // second reset in mid-run must clear the fields again
            if (ep == 12) begin
                reset_n = 1'b0;
                mctrl = '{16'h0000, 16'h0000};
                repeat (3) tick();
                reset_n = 1'b1;
                tick();
            end
        end
        end_sim();
    end
endmodule : tb_bridge_control_decode

`default_nettype wire
